// ### testbench/uart_lin_master_transmitter_tb.sv
// Self-checking bench for the serial transmitter and its register bus.
`timescale 1ns/10ps
`default_nettype none
module uart_lin_master_transmitter_tb;
   import ulmt_pkg::*;
   localparam int BIT_CYC = 400; // Cycles per bit at the fastest legal rate.
   logic ref_clk; // Bench clock.
   logic arst_n; // Reset, active low.
   logic [ADDR_W-1:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [DATA_W-1:0] avs_writedata;
   logic [DATA_W-1:0] avs_readdata;
   logic avs_waitrequest;
   logic irq_mask; // Global interrupt mask.
   logic holding_empty_irq;
   logic frame_done_irq;
   logic tx_out;
   logic tx_oe;
   logic sclk_out;
   logic sclk_oe;
   logic [3:0] data_bits; // Word length the receiver expects.
   logic [8:0] rx_word;
   logic rx_stop;
   int rx_frames;
   int low_cyc;
   int err_total;
   int check_count;
   int sclk_edges = 0; // Rising edges seen on the bit clock.
   logic sclk_prev = 1'b0;
   logic [DATA_W-1:0] rd; // Data of the last bus read.

   ulmt_top uut (.ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .irq_mask(irq_mask), .holding_empty_irq(holding_empty_irq),
      .frame_done_irq(frame_done_irq), .tx_out(tx_out), .tx_oe(tx_oe),
      .sclk_out(sclk_out), .sclk_oe(sclk_oe));

   ulmt_line_model #(.BIT_CYC(BIT_CYC)) line (.ref_clk(ref_clk), .tx_out(tx_out),
      .tx_oe(tx_oe), .data_bits(data_bits), .rx_word(rx_word), .rx_stop(rx_stop),
      .rx_frames(rx_frames), .low_cyc(low_cyc));

   // Clock generator, 5 ns period.
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // Counts bit clock pulses; scenarios compare the difference over one frame.
   always @(posedge ref_clk) begin
      sclk_prev <= sclk_out;
      if (sclk_out === 1'b1 && sclk_prev === 1'b0) begin
         sclk_edges <= sclk_edges + 1;
      end
   end

   // Compares one value and reports a mismatch at once.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One control word bit.
   function automatic logic [31:0] bitv(input int k);
      return 32'h1 << k;
   endfunction

   // Bus write held until waitrequest is seen low.
   task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask

   // Bus read; data is taken at the edge that completes the access.
   task automatic bus_rd(input logic [ADDR_W-1:0] a);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      @(posedge ref_clk);
   endtask

   // Software send sequence: status access, then data write.
   task automatic send(input logic [7:0] d);
      bus_rd(OFS_STATUS);
      bus_wr(OFS_DATA, {24'h000000, d});
   endtask

   // Waits for the receiver to take one frame and judges its content.
   task automatic expect_frame(input logic [8:0] exp);
      int n0;
      n0 = rx_frames;
      while (rx_frames == n0) @(posedge ref_clk);
      check({23'h000000, rx_word}, {23'h000000, exp});
      check({31'h0, rx_stop}, 32'h1);
   endtask

   // Flags and register values right after reset; pin released.
   task automatic t_reset;
      bus_rd(OFS_STATUS);
      check(rd & 32'h3, 32'h3);
      check({31'h0, tx_oe}, 32'h0);
      bus_rd(OFS_CTRL);
      check(rd, {21'h0, CTRL_RST});
      bus_rd(OFS_BAUD);
      check(rd, {16'h0000, DIV_RST});
   endtask

   // Enabling sends a frame of ones, interrupt masking, then a direct start.
   task automatic t_enable;
      int bad;
      int e0;
      bad = 0;
      bus_wr(OFS_CTRL, bitv(CT_TX_ON) | bitv(CT_SCK_EN) | bitv(CT_HE_IE));
      repeat (11 * BIT_CYC) begin
         @(posedge ref_clk);
         if (tx_out !== 1'b1 || tx_oe !== 1'b1) bad++;
      end
      check(32'(bad), 32'h0);
      check({31'h0, holding_empty_irq}, 32'h1);
      irq_mask <= 1'b1;
      @(posedge ref_clk);
      check({31'h0, holding_empty_irq}, 32'h0);
      irq_mask <= 1'b0;
      e0 = sclk_edges;
      send(8'hA5);
      bus_rd(OFS_STATUS);
      check({31'h0, rd[ST_HOLD_EMPTY]}, 32'h1);
      expect_frame(9'h0A5);
      check(32'(sclk_edges - e0), 32'h7);
   endtask

   // Second word written during a frame waits, and both flags clear.
   task automatic t_b2b;
      // Let the previous stop bit finish so the first word starts directly.
      repeat (BIT_CYC) @(posedge ref_clk);
      send(8'h5A);
      send(8'hC3);
      bus_rd(OFS_STATUS);
      check(rd & 32'hB, 32'h8);
      expect_frame(9'h05A);
      expect_frame(9'h0C3);
      repeat (BIT_CYC) @(posedge ref_clk);
      bus_rd(OFS_STATUS);
      check(rd & 32'h3, 32'h3);
   endtask

   // Enable toggled during a frame: held word lost, idle frame owed after the word.
   task automatic t_retoggle;
      int n0;
      send(8'h96);
      send(8'h69);
      bus_wr(OFS_CTRL, 32'h0);
      bus_wr(OFS_CTRL, bitv(CT_TX_ON));
      bus_rd(OFS_STATUS);
      check(rd & 32'h9, 32'h1);
      send(8'hE7);
      expect_frame(9'h096);
      n0 = rx_frames;
      repeat (11 * BIT_CYC) @(posedge ref_clk);
      check(32'(rx_frames - n0), 32'h0);
      expect_frame(9'h0E7);
      repeat (BIT_CYC) @(posedge ref_clk);
   endtask

   // Nine-bit words with the top bit from the control bit, last-bit clock pulse on.
   task automatic t_nine;
      int e0;
      bus_wr(OFS_CTRL, bitv(CT_TX_ON) | bitv(CT_WORD9) | bitv(CT_NINTH) | bitv(CT_SCK_EN)
         | bitv(CT_SCK_LAST));
      data_bits <= 4'h9;
      e0 = sclk_edges;
      send(8'h3C);
      expect_frame(9'h13C);
      check(32'(sclk_edges - e0), 32'h9);
      data_bits <= 4'h8;
   endtask

   // One LIN break, then the mark bit leaves the line high.
   task automatic t_break;
      bus_wr(OFS_CTRL, bitv(CT_TX_ON) | bitv(CT_LIN) | bitv(CT_BREAK));
      repeat (4 * BIT_CYC) @(posedge ref_clk);
      bus_wr(OFS_CTRL, bitv(CT_TX_ON));
      repeat (16 * BIT_CYC) @(posedge ref_clk);
      check(32'(low_cyc), 32'(13 * BIT_CYC));
      check({31'h0, tx_out}, 32'h1);
   endtask

   // Switching off hands the pin back.
   task automatic t_off;
      bus_wr(OFS_CTRL, 32'h0);
      repeat (2) @(posedge ref_clk);
      check({30'h0, tx_oe, sclk_oe}, 32'h0);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic complete_run;
      $display("mismatches %0d comparisons %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Main sequence: reset, then each scenario in turn.
   initial begin
      arst_n = 1'b0;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = '0;
      irq_mask = 1'b0;
      data_bits = 4'h8;
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      t_reset();
      t_enable();
      t_b2b();
      t_retoggle();
      t_nine();
      t_break();
      t_off();
      complete_run();
   end

   // Watchdog, well beyond the expected length of the run.
   initial begin
      repeat (100000) @(posedge ref_clk);
      err_total++;
      complete_run();
   end
endmodule // uart_lin_master_transmitter_tb
`default_nettype wire

// ### testbench/ulmt_line_model.sv
// Receiving serial equipment that samples the transmit line in the middle of each bit.
`timescale 1ns/10ps
`default_nettype none
module ulmt_line_model #(
   parameter int BIT_CYC = 400
) (
   input wire logic ref_clk,
   input wire logic tx_out,
   input wire logic tx_oe,
   input wire logic [3:0] data_bits,
   output logic [8:0] rx_word,
   output logic rx_stop,
   output int rx_frames,
   output int low_cyc
);
   // Length in cycles of the low stretch now running on the line.
   int run_cyc = 0;

   // Frame sampler: a low level starts a frame, then data LSB first, then the stop bit.
   initial begin
      rx_word = 9'h000;
      rx_stop = 1'b0;
      forever begin
         @(posedge ref_clk);
         if (tx_oe === 1'b1 && tx_out === 1'b0) begin
            repeat (BIT_CYC / 2) @(posedge ref_clk);
            rx_word = 9'h000;
            for (int i = 0; i < int'(data_bits); i++) begin
               repeat (BIT_CYC) @(posedge ref_clk);
               rx_word[i] = tx_out;
            end
            repeat (BIT_CYC) @(posedge ref_clk);
            rx_stop = tx_out;
            rx_frames++;
         end
      end
   end

   // Measures every low stretch so break lengths can be judged in whole cycles.
   always @(posedge ref_clk) begin
      if (tx_oe === 1'b1 && tx_out === 1'b0) begin
         run_cyc <= run_cyc + 1;
      end else begin
         if (run_cyc != 0) begin
            low_cyc <= run_cyc;
         end
         run_cyc <= 0;
      end
   end
endmodule // ulmt_line_model
`default_nettype wire

// ### verilog/ulmt_pkg.sv
// Package with register map, field positions, timing constants and types of the transmitter.
`default_nettype none
package ulmt_pkg;
   // Bus geometry.
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   // Register byte offsets.
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_DATA = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_BAUD = 4'hC;
   // Status register bit positions.
   localparam int ST_HOLD_EMPTY = 0;
   localparam int ST_FRAME_DONE = 1;
   localparam int ST_BUSY = 2;
   localparam int ST_HOLD_FULL = 3;
   // Control register bit positions.
   localparam int CT_TX_ON = 0;
   localparam int CT_BREAK = 1;
   localparam int CT_WORD9 = 2;
   localparam int CT_NINTH = 3;
   localparam int CT_LIN = 4;
   localparam int CT_HE_IE = 5;
   localparam int CT_FD_IE = 6;
   localparam int CT_SCK_EN = 7;
   localparam int CT_SCK_POL = 8;
   localparam int CT_SCK_PH = 9;
   localparam int CT_SCK_LAST = 10;
   localparam int CTRL_W = 11;
   localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
   // Frame geometry.
   localparam int FRAME_W = 13;
   localparam logic [3:0] LEN_8 = 4'hA;
   localparam logic [3:0] LEN_9 = 4'hB;
   localparam logic [3:0] LEN_LIN_BRK = 4'hD;
   localparam logic [3:0] LEN_MARK = 4'h1;
   localparam logic [3:0] IDX_NINTH = 4'h9;
   // Bit timing.
   localparam longint CLK_HZ = 200000000;
   localparam longint MAX_BAUD = 500000;
   localparam int MIN_BIT_CYC = int'((CLK_HZ + MAX_BAUD - 1) / MAX_BAUD);
   localparam int DIV_W = 16;
   localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'(MIN_BIT_CYC);
   localparam logic [DIV_W-1:0] DIV_RST = DIV_W'(MIN_BIT_CYC);
   // Engine states.
   typedef enum logic [0:0] {S_IDLE = 1'b0, S_SEND = 1'b1} ulmt_state_e;
   // Kinds of frame the engine can send.
   typedef enum logic [1:0] {
      K_DATA = 2'b00, K_IDLE = 2'b01, K_BREAK = 2'b10, K_MARK = 2'b11
   } ulmt_kind_e;
   // A built frame: bit pattern, LSB goes first, and its length in bits.
   typedef struct packed {
      logic [3:0] len;
      logic [FRAME_W-1:0] bits;
   } ulmt_frame_s;
endpackage
`default_nettype wire

// ### verilog/ulmt_top.sv
// Serial transmitter with holding buffer, idle and break frames, bit clock and Avalon-MM slave.
//
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Start bit, eight or nine data LSB first, stop.
// - Start bit low, stop bit high.
// - Enabled and empty: serial output rests high.
// - Disabled transmitter releases pin to port function.
// - Nine-bit mode takes top bit from ninth-bit control.
// - Bit clock pulses on data bits, programmable options.
// - Enabling sends one idle frame first.
// - Enable toggle mid-frame sends idle after word.
// - Enable toggle discards word in holding buffer.
// - Holding-empty clears after status read, data write.
// - Write during frame waits in holding buffer.
// - Write while idle starts directly, flag stays set.
// - Holding-empty requests interrupt when enabled, unmasked.
// - Frame-done sets after stop or break; interrupts.
// - Frame-done cleared by same status-then-write pair.
// - Break frame length follows word-length select.
// - Breaks repeat while set; then one mark bit.
// - Transmit bit rate programmable, at most 500K.
// - Idle is frame of ones; break all zeros.
// - LIN master eight-bit break is thirteen low bits.
module ulmt_top (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [ulmt_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [ulmt_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [ulmt_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic irq_mask,
   output logic holding_empty_irq,
   output logic frame_done_irq,
   output logic tx_out,
   output logic tx_oe,
   output logic sclk_out,
   output logic sclk_oe
);
   import ulmt_pkg::*;

   // Merges written byte lanes into an existing register value.
   function automatic logic [DATA_W-1:0] merge_be(input logic [DATA_W-1:0] old_v,
                                                  input logic [DATA_W-1:0] new_v,
                                                  input logic [3:0] be);
      logic [DATA_W-1:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Builds the bit pattern and length of one frame of the given kind.
   function automatic ulmt_frame_s build_frame(input ulmt_kind_e kind, input logic word9,
                                               input logic ninth, input logic lin,
                                               input logic [7:0] data);
      ulmt_frame_s f;
      f.len = word9 ? LEN_9 : LEN_8;
      f.bits = '1;
      case (kind)
         K_DATA: begin
            f.bits = word9 ? {2'b11, 1'b1, ninth, data, 1'b0} : {3'b111, 1'b1, data, 1'b0};
         end
         K_IDLE: begin
            f.bits = '1;
         end
         K_BREAK: begin
            f.bits = '0;
            if (lin && !word9) begin
               f.len = LEN_LIN_BRK;
            end
         end
         K_MARK: begin
            f.len = LEN_MARK;
         end
         default: begin
            f.bits = '1;
         end
      endcase
      return f;
   endfunction

   // Software-visible state.
   logic [CTRL_W-1:0] ctrl_reg; // Control bits.
   logic [DIV_W-1:0] baud_reg; // Cycles per bit as written.
   logic [7:0] tx_holding_buffer; // Word waiting behind the shifter.
   logic hold_full_reg; // Holding buffer holds a word.
   logic tx_holding_empty_flag; // Sticky holding-empty flag.
   logic frame_done_flag; // Sticky frame-done flag.
   logic armed_reg; // A status read has happened since the last data write.
   // Engine state.
   ulmt_state_e state_reg; // Idle or sending.
   ulmt_kind_e kind_reg; // Kind of frame on the line.
   logic [FRAME_W-1:0] shift_reg; // Frame bits, LSB on the line.
   logic [3:0] len_reg; // Length of current frame.
   logic [3:0] idx_reg; // Bit being sent.
   logic [DIV_W-1:0] cnt_reg; // Cycle count within a bit.
   logic idle_pending_reg; // An idle frame is owed.
   logic brk_seen_reg; // A break went out and no mark has followed yet.
   logic tx_on_q; // Previous value of the enable.
   logic ack_reg; // Second cycle of a bus access.
   logic [DATA_W-1:0] rdata_reg; // Captured read data.
   logic sclk_reg; // Registered bit clock.

   // Named control fields.
   logic tx_on, break_send, word9, tx_ninth_bit, lin_master;
   logic holding_empty_irq_en, frame_done_irq_en;
   assign tx_on = ctrl_reg[CT_TX_ON];
   assign break_send = ctrl_reg[CT_BREAK];
   assign word9 = ctrl_reg[CT_WORD9];
   assign tx_ninth_bit = ctrl_reg[CT_NINTH];
   assign lin_master = ctrl_reg[CT_LIN];
   assign holding_empty_irq_en = ctrl_reg[CT_HE_IE];
   assign frame_done_irq_en = ctrl_reg[CT_FD_IE];

   // Bus access decode; each access takes a wait cycle then completes.
   logic acc, rd_acc, wr_acc, status_rd, data_wr, ctrl_wr, baud_wr;
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
   assign acc = (avs_read | avs_write) & ack_reg;
   assign rd_acc = acc & avs_read;
   assign wr_acc = acc & avs_write;
   assign status_rd = rd_acc & (avs_address == OFS_STATUS);
   assign data_wr = wr_acc & (avs_address == OFS_DATA) & avs_byteenable[0];
   assign ctrl_wr = wr_acc & (avs_address == OFS_CTRL);
   assign baud_wr = wr_acc & (avs_address == OFS_BAUD);
   assign avs_readdata = rdata_reg;

   // Bit timing: the divider never drops below the fastest legal bit time.
   logic [DIV_W-1:0] div_eff;
   logic bit_tick, frame_end, tx_on_rise;
   assign div_eff = (baud_reg < DIV_MIN) ? DIV_MIN : baud_reg;
   assign bit_tick = (state_reg == S_SEND) && (cnt_reg == div_eff - DIV_W'(1));
   assign frame_end = bit_tick && (idx_reg == len_reg - 4'h1);
   assign tx_on_rise = tx_on & ~tx_on_q;

   // Chooses the next frame; a frame may start only with the transmitter on.
   logic can_launch, launch, launch_direct;
   ulmt_kind_e next_kind;
   ulmt_frame_s next_frame;
   always_comb begin
      can_launch = tx_on && !tx_on_rise && ((state_reg == S_IDLE) || frame_end);
      launch = 1'b0;
      next_kind = K_IDLE;
      if (brk_seen_reg && !break_send) begin
         launch = can_launch;
         next_kind = K_MARK;
      end else if (idle_pending_reg) begin
         launch = can_launch;
         next_kind = K_IDLE;
      end else if (break_send) begin
         launch = can_launch;
         next_kind = K_BREAK;
      end else if (hold_full_reg || data_wr) begin
         launch = can_launch;
         next_kind = K_DATA;
      end
      launch_direct = launch && (next_kind == K_DATA) && !hold_full_reg;
      next_frame = build_frame(next_kind, word9, tx_ninth_bit, lin_master,
                               hold_full_reg ? tx_holding_buffer : avs_writedata[7:0]);
   end

   // Bus read data and access phase.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_reg <= 1'b0;
         rdata_reg <= '0;
      end else begin
         ack_reg <= (avs_read | avs_write) & ~ack_reg;
         if (avs_read && !ack_reg) begin
            case (avs_address)
               OFS_STATUS: begin
                  rdata_reg <= DATA_W'({hold_full_reg, (state_reg == S_SEND),
                                        frame_done_flag, tx_holding_empty_flag});
               end
               OFS_DATA: begin
                  rdata_reg <= DATA_W'(tx_holding_buffer);
               end
               OFS_CTRL: begin
                  rdata_reg <= DATA_W'(ctrl_reg);
               end
               OFS_BAUD: begin
                  rdata_reg <= DATA_W'(baud_reg);
               end
               default: begin
                  rdata_reg <= '0; // Unmapped offsets read as zero.
               end
            endcase
         end
      end
   end

   // Control and baud registers written by software.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg <= CTRL_RST;
         baud_reg <= DIV_RST;
         tx_on_q <= 1'b0;
      end else begin
         tx_on_q <= tx_on;
         if (ctrl_wr) begin
            ctrl_reg <= CTRL_W'(merge_be(DATA_W'(ctrl_reg), avs_writedata, avs_byteenable));
         end
         if (baud_wr) begin
            baud_reg <= DIV_W'(merge_be(DATA_W'(baud_reg), avs_writedata, avs_byteenable));
         end
      end
   end

   // Status access arms the clear; the following data write disarms it.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         armed_reg <= 1'b0;
      end else if (data_wr) begin
         armed_reg <= 1'b0;
      end else if (status_rd) begin
         armed_reg <= 1'b1;
      end
   end

   // Holding buffer; a re-enable throws its word away.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_holding_buffer <= '0;
         hold_full_reg <= 1'b0;
      end else begin
         if (data_wr && !launch_direct) begin
            tx_holding_buffer <= avs_writedata[7:0];
         end
         if (tx_on_rise) begin
            hold_full_reg <= 1'b0;
         end else if (data_wr && !launch_direct) begin
            hold_full_reg <= 1'b1;
         end else if (launch && next_kind == K_DATA) begin
            hold_full_reg <= 1'b0;
         end
      end
   end

   // Sticky flags; a hardware set wins over the software clear.
   logic empty_set, done_set, seq_clr;
   assign empty_set = (launch && next_kind == K_DATA) || tx_on_rise;
   assign done_set = frame_end && (kind_reg == K_DATA || kind_reg == K_BREAK);
   assign seq_clr = data_wr && armed_reg;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_holding_empty_flag <= 1'b1;
         frame_done_flag <= 1'b1;
      end else begin
         tx_holding_empty_flag <= empty_set | (tx_holding_empty_flag & ~seq_clr);
         frame_done_flag <= done_set | (frame_done_flag & ~seq_clr);
      end
   end

   // Owed idle frame and pending mark bit after breaks.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         idle_pending_reg <= 1'b0;
         brk_seen_reg <= 1'b0;
      end else begin
         if (tx_on_rise) begin
            idle_pending_reg <= 1'b1;
         end else if (launch && next_kind == K_IDLE) begin
            idle_pending_reg <= 1'b0;
         end
         if (launch && next_kind == K_BREAK) begin
            brk_seen_reg <= 1'b1;
         end else if (launch && next_kind == K_MARK) begin
            brk_seen_reg <= 1'b0;
         end
      end
   end

   // Frame engine: loads a frame, shifts one bit per bit time, refills with ones.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= S_IDLE;
         kind_reg <= K_IDLE;
         shift_reg <= '1;
         len_reg <= LEN_8;
         idx_reg <= '0;
         cnt_reg <= '0;
      end else if (launch) begin
         state_reg <= S_SEND;
         kind_reg <= next_kind;
         shift_reg <= next_frame.bits;
         len_reg <= next_frame.len;
         idx_reg <= '0;
         cnt_reg <= '0;
      end else if (frame_end) begin
         state_reg <= S_IDLE;
         shift_reg <= '1;
         idx_reg <= '0;
         cnt_reg <= '0;
      end else if (bit_tick) begin
         shift_reg <= {1'b1, shift_reg[FRAME_W-1:1]};
         idx_reg <= idx_reg + 4'h1;
         cnt_reg <= '0;
      end else if (state_reg == S_SEND) begin
         cnt_reg <= cnt_reg + DIV_W'(1);
      end
   end

   // Bit clock: active in one half of each data bit, last bit optional.
   logic data_bit, pulse_bit, second_half;
   assign data_bit = (state_reg == S_SEND) && (kind_reg == K_DATA) && (idx_reg != 4'h0)
                     && (idx_reg < len_reg - 4'h1);
   assign pulse_bit = data_bit && ((idx_reg < len_reg - 4'h2) || ctrl_reg[CT_SCK_LAST]);
   assign second_half = cnt_reg >= (div_eff >> 1);
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sclk_reg <= 1'b0;
      end else begin
         sclk_reg <= ctrl_reg[CT_SCK_POL]
                     ^ (pulse_bit && (second_half ^ ~ctrl_reg[CT_SCK_PH]));
      end
   end

   // Pin outputs: the pin is driven while enabled or finishing a frame.
   assign tx_out = shift_reg[0];
   assign tx_oe = tx_on | (state_reg == S_SEND);
   assign sclk_out = sclk_reg;
   assign sclk_oe = tx_oe & ctrl_reg[CT_SCK_EN];
   assign holding_empty_irq = tx_holding_empty_flag & holding_empty_irq_en & ~irq_mask;
   assign frame_done_irq = frame_done_flag & frame_done_irq_en & ~irq_mask;

   // Checks next to the logic above.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   sequence s_break_over;
      frame_end && kind_reg == K_BREAK && !break_send && tx_on && !tx_on_rise;
   endsequence

   a_idle_line_high: assert property ((state_reg == S_IDLE) |-> tx_out)
      else $error("Line not high while idle.");
   a_pin_released: assert property ((!tx_on && state_reg == S_IDLE) |-> !tx_oe)
      else $error("Pin driven while transmitter off.");
   a_start_bit_low: assert property ((launch && next_kind == K_DATA) |=> !tx_out)
      else $error("Start bit not low.");
   a_stop_bit_high: assert property ((state_reg == S_SEND && kind_reg == K_DATA
      && idx_reg == len_reg - 4'h1) |-> tx_out)
      else $error("Stop bit not high.");
   a_ninth_bit_src: assert property ((launch && next_kind == K_DATA && word9)
      |=> shift_reg[IDX_NINTH] == $past(tx_ninth_bit))
      else $error("Ninth bit not from control.");
   a_set_beats_clr: assert property ((empty_set && seq_clr) |=> tx_holding_empty_flag)
      else $error("Set lost against clear.");
   a_seq_clears: assert property ((seq_clr && !empty_set && !done_set)
      |=> !tx_holding_empty_flag && !frame_done_flag)
      else $error("Status-then-write did not clear.");
   a_done_on_end: assert property (done_set |=> frame_done_flag)
      else $error("Frame-done not set.");
   a_discard_hold: assert property (tx_on_rise |=> !hold_full_reg && idle_pending_reg)
      else $error("Holding word kept over re-enable.");
   a_break_low: assert property ((state_reg == S_SEND && kind_reg == K_BREAK) |-> !tx_out)
      else $error("Break frame not low.");
   a_lin_break_len: assert property ((launch && next_kind == K_BREAK && lin_master && !word9)
      |=> len_reg == LEN_LIN_BRK)
      else $error("LIN break not thirteen bits.");
   a_mark_after_brk: assert property (s_break_over |=> kind_reg == K_MARK ##0 tx_out)
      else $error("No mark bit after break.");
   a_sclk_quiet: assert property ((!pulse_bit) |=> sclk_out == $past(ctrl_reg[CT_SCK_POL]))
      else $error("Bit clock pulsed outside data bit.");
endmodule // ulmt_top
`default_nettype wire
